// ===== drc_regs.vh
`ifndef DRC_REGS_VH
`define DRC_REGS_VH

// clock period in ps (125 MHz)
`define DRC_CLK_PS          32'd8000
// timing figures as printed
`define DRC_PWRUP_US        32'd200
`define DRC_REF_PERIOD_MS   32'd8
`define DRC_REF_ROWS        32'd512
`define DRC_CBR_SETUP_NS    32'd10
`define DRC_CBR_HOLD_NS     32'd15
`define DRC_RAS_PRE_NS      32'd40
`define DRC_RAS_LOW_NS      32'd60
`define DRC_RAS_MAX_NS      32'd10000
`define DRC_RC_NS           32'd110
`define DRC_CAS_HIGH_NS     32'd10
`define DRC_CAS_LOW_NS      32'd15
`define DRC_RCD_NS          32'd20
`define DRC_INIT_CYCLES     32'd8

// cycle counts derived from the figures; least times round up
`define DRC_CYC_UP(ns)      (((ns) * 32'd1000 + `DRC_CLK_PS - 32'd1) / `DRC_CLK_PS)
`define DRC_CYC_DN(ns)      (((ns) * 32'd1000) / `DRC_CLK_PS)
`define DRC_PWRUP_CYC       ((`DRC_PWRUP_US * 32'd1000000) / `DRC_CLK_PS)
// divide by the row count before scaling to ps so no product leaves 32 bits
`define DRC_REF_INT_CYC     ((((`DRC_REF_PERIOD_MS * 32'd1000000) / `DRC_REF_ROWS) * 32'd1000) / `DRC_CLK_PS)
`define DRC_CBR_SETUP_CYC   `DRC_CYC_UP(`DRC_CBR_SETUP_NS)
`define DRC_CBR_HOLD_CYC    `DRC_CYC_UP(`DRC_CBR_HOLD_NS)
`define DRC_RAS_PRE_CYC     `DRC_CYC_UP(`DRC_RAS_PRE_NS)
`define DRC_RAS_LOW_CYC     `DRC_CYC_UP(`DRC_RAS_LOW_NS)
`define DRC_RAS_MAX_CYC     `DRC_CYC_DN(`DRC_RAS_MAX_NS)
`define DRC_RC_CYC          `DRC_CYC_UP(`DRC_RC_NS)
`define DRC_CAS_HIGH_CYC    `DRC_CYC_UP(`DRC_CAS_HIGH_NS)
`define DRC_CAS_LOW_CYC     `DRC_CYC_UP(`DRC_CAS_LOW_NS)
`define DRC_RCD_CYC         `DRC_CYC_UP(`DRC_RCD_NS)

`endif

// ===== drc_timer.v
`timescale 1ns/1ps
// loadable down counter; done is registered and high while count is zero
module drc_timer
(
    input  wire        core_clk_i,
    input  wire        nrst_i,
    input  wire        load_i,
    input  wire [15:0] value_i,
    output reg         done_o
);
    reg [15:0] cnt_q;

    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            cnt_q  <= 16'h0000;
            done_o <= 1'b1;
        end
        else if (load_i)
        begin
            cnt_q  <= value_i;
            done_o <= (value_i == 16'h0000);
        end
        else if (cnt_q != 16'h0000)
        begin
            cnt_q  <= cnt_q - 16'h0001;
            done_o <= (cnt_q == 16'h0001);
        end
    end
endmodule

// ===== drc_ctrl.v
`timescale 1ns/1ps
`include "drc_regs.vh"

// Functional notes
// - all 512 rows refreshed every 8 ms
// - row-only refresh drives row on address; the controller uses only column-first refresh instead
// - hidden refresh: column strobe held low; the controller raises the column strobe at the end of each access instead
// - column strobe low 10 ns before row
// - successive column-first refreshes keep column low
// - 200 us pause, then eight init cycles
// - row strobe low at most 10000 ns
// - row strobe high at least 40 ns
// - read cycles spaced at least 110 ns
// - column strobe high 10 ns between columns
// - write enable high reads, low writes
module drc_ctrl
#(
    parameter PWRUP_CYC   = `DRC_PWRUP_CYC,
    parameter REF_INT_CYC = `DRC_REF_INT_CYC
)
(
    input  wire        core_clk_i,
    input  wire        nrst_i,
    input  wire        req_valid_i,
    input  wire        req_write_i,
    input  wire [17:0] req_addr_i,
    input  wire [3:0]  req_wdata_i,
    output reg         req_ready_o,
    output reg         rsp_valid_o,
    output reg  [3:0]  rsp_rdata_o,
    output reg         init_done_o,
    output reg         ras_n_o,
    output reg         cas_n_o,
    output reg         we_n_o,
    output reg         oe_n_o,
    output reg  [8:0]  mux_address_bus_o,
    output reg  [3:0]  data_pins_o,
    output reg         data_pins_oe_n_o,
    input  wire [3:0]  data_pins_i
);
    localparam [9:0] ST_PWRUP  = 10'h001;
    localparam [9:0] ST_IDLE   = 10'h002;
    localparam [9:0] ST_CSETUP = 10'h004;
    localparam [9:0] ST_CREF   = 10'h008;
    localparam [9:0] ST_RROW   = 10'h010;
    localparam [9:0] ST_RCD    = 10'h020;
    localparam [9:0] ST_CAS    = 10'h040;
    localparam [9:0] ST_RASEND = 10'h080;
    localparam [9:0] ST_PRE    = 10'h100;
    localparam [9:0] ST_ACC    = 10'h200;

    function [15:0] cyc16;
        input [31:0] v;
        begin
            cyc16 = v[15:0];
        end
    endfunction

    reg  [9:0]  st_q;
    reg  [31:0] pwr_cnt_q;
    reg  [31:0] ref_cnt_q;
    reg  [3:0]  init_cnt_q;
    reg         ref_pend_q;
    reg         wr_q;
    reg  [17:0] addr_q;
    reg  [3:0]  wdata_q;
    reg  [3:0]  din_s1_q;
    reg  [3:0]  din_s2_q;
    reg         tmr_load;
    reg  [15:0] tmr_val;
    wire        tmr_done;

    drc_timer u_timer
    (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .load_i     (tmr_load),
        .value_i    (tmr_val),
        .done_o     (tmr_done)
    );

    // data pins come from another timing domain
    always @(posedge core_clk_i)
    begin
        din_s1_q <= data_pins_i;
        din_s2_q <= din_s1_q;
    end

    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
            ref_cnt_q <= 32'h0000_0000;
        else if (ref_cnt_q >= REF_INT_CYC - 1)
            ref_cnt_q <= 32'h0000_0000;
        else
            ref_cnt_q <= ref_cnt_q + 32'h0000_0001;
    end

    always @*
    begin
        tmr_load = 1'b0;
        tmr_val  = 16'h0000;
        case (st_q)
            ST_IDLE:
            begin
                tmr_load = 1'b1;
                tmr_val  = cyc16(`DRC_CBR_SETUP_CYC);
                if (req_valid_i && req_ready_o)
                    tmr_val = cyc16(`DRC_RCD_CYC);
            end
            ST_CSETUP:
            begin
                tmr_load = tmr_done;
                tmr_val  = cyc16(`DRC_RAS_LOW_CYC);
            end
            ST_CREF, ST_RASEND:
            begin
                tmr_load = tmr_done;
                tmr_val  = cyc16(`DRC_RAS_PRE_CYC);
            end
            ST_RCD:
            begin
                tmr_load = tmr_done;
                tmr_val  = cyc16(`DRC_CAS_LOW_CYC);
            end
            ST_CAS:
            begin
                tmr_load = tmr_done;
                tmr_val  = cyc16(`DRC_RC_CYC - `DRC_RAS_PRE_CYC - `DRC_RCD_CYC - `DRC_CAS_LOW_CYC);
            end
            default:
            begin
                tmr_load = 1'b0;
                tmr_val  = 16'h0000;
            end
        endcase
    end

    always @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            st_q              <= ST_PWRUP;
            pwr_cnt_q         <= 32'h0000_0000;
            init_cnt_q        <= 4'h0;
            ref_pend_q        <= 1'b0;
            wr_q              <= 1'b0;
            addr_q            <= 18'h00000;
            wdata_q           <= 4'h0;
            req_ready_o       <= 1'b0;
            rsp_valid_o       <= 1'b0;
            rsp_rdata_o       <= 4'h0;
            init_done_o       <= 1'b0;
            ras_n_o           <= 1'b1;
            cas_n_o           <= 1'b1;
            we_n_o            <= 1'b1;
            oe_n_o            <= 1'b1;
            mux_address_bus_o <= 9'h000;
            data_pins_o       <= 4'h0;
            data_pins_oe_n_o  <= 1'b1;
        end
        else
        begin
            rsp_valid_o <= 1'b0;
            // a tick wins over the clear done in the refresh sequence
            if (ref_cnt_q >= REF_INT_CYC - 1)
                ref_pend_q <= 1'b1;
            else if (st_q == ST_CSETUP && tmr_done)
                ref_pend_q <= 1'b0;
            case (st_q)
                ST_PWRUP:
                begin
                    if (pwr_cnt_q >= PWRUP_CYC - 1)
                        st_q <= ST_IDLE;
                    else
                        pwr_cnt_q <= pwr_cnt_q + 32'h0000_0001;
                end
                ST_IDLE:
                begin
                    // a ready already shown is honoured; a pending refresh waits one access at most
                    if (req_valid_i && req_ready_o)
                    begin
                        req_ready_o       <= 1'b0;
                        wr_q              <= req_write_i;
                        addr_q            <= req_addr_i;
                        wdata_q           <= req_wdata_i;
                        mux_address_bus_o <= req_addr_i[17:9];
                        ras_n_o           <= 1'b0;
                        st_q              <= ST_RCD;
                    end
                    else if (ref_pend_q || !init_done_o)
                    begin
                        req_ready_o <= 1'b0;
                        cas_n_o     <= 1'b0;
                        st_q        <= ST_CSETUP;
                    end
                    else
                        req_ready_o <= 1'b1;
                end
                ST_CSETUP:
                begin
                    if (tmr_done)
                    begin
                        ras_n_o <= 1'b0;
                        st_q    <= ST_CREF;
                    end
                end
                ST_CREF:
                begin
                    // row low time bounded by the timer
                    if (tmr_done)
                    begin
                        ras_n_o <= 1'b1;
                        // column stays low for back-to-back refreshes
                        cas_n_o <= !(ref_pend_q || init_cnt_q < `DRC_INIT_CYCLES - 1);
                        if (!init_done_o)
                            init_cnt_q <= init_cnt_q + 4'h1;
                        st_q <= ST_PRE;
                    end
                end
                ST_RCD:
                begin
                    if (tmr_done)
                    begin
                        mux_address_bus_o <= addr_q[8:0];
                        we_n_o            <= !wr_q;
                        oe_n_o            <= wr_q;
                        data_pins_o       <= wdata_q;
                        data_pins_oe_n_o  <= !wr_q;
                        cas_n_o           <= 1'b0;
                        st_q              <= ST_CAS;
                    end
                end
                ST_CAS:
                begin
                    if (tmr_done)
                    begin
                        rsp_rdata_o      <= din_s2_q;
                        rsp_valid_o      <= !wr_q;
                        // column high through row end and precharge
                        cas_n_o          <= 1'b1;
                        we_n_o           <= 1'b1;
                        oe_n_o           <= 1'b1;
                        data_pins_oe_n_o <= 1'b1;
                        st_q             <= ST_RASEND;
                    end
                end
                ST_RASEND:
                begin
                    // row stays low to fill the read cycle
                    if (tmr_done)
                    begin
                        ras_n_o <= 1'b1;
                        st_q    <= ST_PRE;
                    end
                end
                ST_PRE:
                begin
                    // precharge before the next row cycle
                    if (tmr_done)
                    begin
                        // ready after pause and eight cycles
                        if (init_cnt_q >= `DRC_INIT_CYCLES)
                            init_done_o <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// ===== drc_ctrl_monitor.sv
`timescale 1ns/1ps
module drc_ctrl_monitor
#(
    parameter PWRUP_CYC   = 25000,
    parameter REF_INT_CYC = 1953
)
(
    input wire core_clk_i,
    input wire nrst_i,
    input wire req_ready_o,
    input wire init_done_o,
    input wire ras_n_o,
    input wire cas_n_o,
    input wire we_n_o,
    input wire oe_n_o,
    input wire data_pins_oe_n_o
);
    reg        ras_p_q;
    reg [15:0] low_q;
    reg [7:0]  rd_q;
    reg [3:0]  nfall_q;
    wire       fall = ras_p_q && !ras_n_o;
    default clocking dcb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // rd_q counts from the last access row opening (column high at row fall), saturating
    always @(posedge core_clk_i)
    begin
        ras_p_q <= ras_n_o;
        low_q   <= ras_n_o ? 16'h0 : low_q + 16'h1;
        if (!nrst_i)
        begin
            rd_q    <= 8'hff;
            nfall_q <= 4'h0;
        end
        else
        begin
            rd_q    <= (fall && cas_n_o) ? 8'h0 : ((rd_q == 8'hff) ? rd_q : rd_q + 8'h1);
            nfall_q <= (fall && nfall_q != 4'hf) ? nfall_q + 4'h1 : nfall_q;
        end
    end
    chk_cbr_setup: assert property (fall && !cas_n_o |-> !$past(cas_n_o, 2))
        else $error("cbr setup short");
    chk_cbr_hold: assert property (fall && !cas_n_o |=> !cas_n_o)
        else $error("cbr hold short");
    chk_row_precharge: assert property ($rose(ras_n_o) |-> ras_n_o[*5])
        else $error("row precharge short");
    chk_row_low_max: assert property (low_q <= 16'd1250)
        else $error("row low too long");
    chk_read_cycle: assert property (fall && cas_n_o |-> rd_q >= 8'd13)
        else $error("read cycle short");
    chk_col_precharge: assert property ($rose(cas_n_o) |-> cas_n_o[*2])
        else $error("column high short");
    chk_init_count: assert property ($rose(init_done_o) |-> nfall_q >= 4'd8)
        else $error("init cycles missing");
    chk_ready_after_init: assert property (req_ready_o |-> init_done_o)
        else $error("ready before init");
    chk_bus_turn: assert property (!cas_n_o && !oe_n_o |-> data_pins_oe_n_o && we_n_o)
        else $error("data pin contention");
endmodule

// ===== drc_mem_model.sv
`timescale 1ns/1ps
module drc_mem_model
(
    input  wire        clk_i,
    input  wire        ras_n_i,
    input  wire        cas_n_i,
    input  wire        we_n_i,
    input  wire        oe_n_i,
    input  wire [8:0]  a_i,
    input  wire [3:0]  d_i,
    input  wire        d_oe_n_i,
    output wire [3:0]  q_o,
    output reg  [15:0] refs_o = 16'h0
);
    reg [3:0] mem [0:262143];
    reg [8:0] row_q;
    reg [3:0] dout_q;
    reg       ras_q  = 1'b1;
    reg       cas_q  = 1'b1;
    reg       rd_q   = 1'b0;
    reg [3:0] last_q = 4'h0;
    // drive only in reads; data flows from column strobe fall, then is latched and held until column rises
    assign q_o = (!cas_n_i && !oe_n_i && we_n_i && (rd_q || !ras_n_i)) ?
                 (rd_q ? dout_q : mem[{row_q, a_i}]) : ~last_q;
    // strobes sampled on the controller clock; floating pins toggle each cycle
    always @(posedge clk_i)
    begin
        ras_q  <= ras_n_i;
        cas_q  <= cas_n_i;
        last_q <= q_o;
        if (ras_q && !ras_n_i && !cas_n_i)
            refs_o <= refs_o + 16'h1;
        if (ras_q && !ras_n_i && cas_n_i)
            row_q <= a_i;
        if (cas_n_i)
            rd_q <= 1'b0;
        if (cas_q && !cas_n_i && !ras_n_i)
        begin
            rd_q   <= we_n_i;
            dout_q <= mem[{row_q, a_i}];
            if (!we_n_i)
                mem[{row_q, a_i}] <= d_oe_n_i ? 4'hx : d_i;
        end
    end
endmodule

// ===== dram_refresh_and_cycle_timing_tb.sv
`timescale 1ns/1ps
module dram_refresh_and_cycle_timing_tb;
    localparam PWRUP_CYC   = 20;
    localparam REF_INT_CYC = 200;
    reg         clk;
    reg         rst_n;
    reg         vld;
    reg         wr;
    reg  [17:0] adr;
    reg  [3:0]  wd;
    wire        rdy, rv, done, ras_n, cas_n, we_n, oe_n, dq_oen;
    wire [3:0]  rd, dq_o, dq_i;
    wire [8:0]  ma;
    wire [15:0] refs;
    integer     miscompares = 0;
    integer     compares = 0;
    integer     cycles = 0;
    drc_ctrl #(.PWRUP_CYC(PWRUP_CYC), .REF_INT_CYC(REF_INT_CYC)) u_dut (.core_clk_i(clk), .nrst_i(rst_n),
        .req_valid_i(vld), .req_write_i(wr), .req_addr_i(adr), .req_wdata_i(wd), .req_ready_o(rdy),
        .rsp_valid_o(rv), .rsp_rdata_o(rd), .init_done_o(done), .ras_n_o(ras_n), .cas_n_o(cas_n),
        .we_n_o(we_n), .oe_n_o(oe_n), .mux_address_bus_o(ma), .data_pins_o(dq_o),
        .data_pins_oe_n_o(dq_oen), .data_pins_i(dq_i));
    drc_mem_model u_mem (.clk_i(clk), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .oe_n_i(oe_n),
        .a_i(ma), .d_i(dq_o), .d_oe_n_i(dq_oen), .q_o(dq_i), .refs_o(refs));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles > 20000)
        begin
            miscompares = miscompares + 1;
            stop_test;
        end
    end
    task check(input [17:0] got, input [17:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp)
            begin
                miscompares = miscompares + 1;
                $display("mismatch t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task stop_test;
        begin
            $display("compares %0d miscompares %0d", compares, miscompares);
            if (miscompares == 0 && compares > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    // request held until taken; read data taken at the response edge
    // waits end at the cycle watchdog, which counts a mismatch
    task access(input w, input [17:0] a, input [3:0] d, output [3:0] q);
        begin
            @(posedge clk);
            vld <= 1'b1;
            wr <= w;
            adr <= a;
            wd <= d;
            @(posedge clk);
            while (rdy !== 1'b1)
                @(posedge clk);
            vld <= 1'b0;
            while (!w && rv !== 1'b1)
                @(posedge clk);
            q = rd;
        end
    endtask
    task wait_done(input [15:0] r0);
        begin
            while (done !== 1'b1)
                @(posedge clk);
            check(18'(refs - r0 >= 16'd8), 18'h1);
        end
    endtask
    task t_init;
        integer n;
        begin
            n = 0;
            while (ras_n === 1'b1)
            begin
                n = n + 1;
                @(posedge clk);
            end
            check(18'(n > PWRUP_CYC), 18'h1);
            wait_done(16'h0000);
            $display("init end");
        end
    endtask
    task t_rw;
        logic [17:0] tbl [5];
        logic [3:0]  q;
        integer      i;
        begin
            tbl = '{18'h00000, 18'h3ffff, 18'h001ff, 18'h3fe00, 18'h12345};
            for (i = 0; i < 5; i++)
                access(1'b1, tbl[i], 4'(i) ^ 4'h9, q);
            for (i = 0; i < 5; i++)
            begin
                access(1'b0, tbl[i], 4'h0, q);
                check(18'(q), 18'(4'(i) ^ 4'h9));
            end
            $display("rw end");
        end
    endtask
    task t_busy;
        logic [3:0]  q;
        logic [15:0] r0;
        integer      c0;
        integer      i;
        begin
            r0 = refs;
            c0 = cycles;
            repeat (3 * REF_INT_CYC) @(posedge clk);
            for (i = 0; i < 60; i++)
            begin
                access(1'b0, 18'h3ffff, 4'h0, q);
                check(18'(q), 18'h8);
            end
            check(18'(refs - r0 >= (cycles - c0) / REF_INT_CYC - 1), 18'h1);
            $display("busy end");
        end
    endtask
    task t_rst;
        logic [3:0]  q;
        logic [15:0] r0;
        begin
            access(1'b1, 18'h00100, 4'h5, q);
            @(posedge clk);
            vld <= 1'b1;
            wr <= 1'b0;
            repeat (3) @(posedge clk);
            rst_n <= 1'b0;
            vld <= 1'b0;
            repeat (2) @(posedge clk);
            check(18'({done, rdy, ras_n, cas_n, we_n, oe_n, dq_oen}), 18'h1f);
            r0 = refs;
            rst_n <= 1'b1;
            wait_done(r0);
            access(1'b0, 18'h00100, 4'h0, q);
            check(18'(q), 18'h5);
            $display("reset end");
        end
    endtask
    initial
    begin
        rst_n = 1'b0;
        vld = 1'b0;
        wr = 1'b0;
        adr = 18'h0;
        wd = 4'h0;
        repeat (4) @(posedge clk);
        check(18'({done, rdy, ras_n, cas_n, we_n, oe_n, dq_oen}), 18'h1f);
        rst_n <= 1'b1;
        t_init;
        t_rw;
        t_busy;
        t_rst;
        stop_test;
    end
endmodule
bind drc_ctrl drc_ctrl_monitor #(.PWRUP_CYC(PWRUP_CYC), .REF_INT_CYC(REF_INT_CYC)) u_mon (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .req_ready_o(req_ready_o), .init_done_o(init_done_o), .ras_n_o(ras_n_o),
    .cas_n_o(cas_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o), .data_pins_oe_n_o(data_pins_oe_n_o));
